// File: twc_pkg.sv
package twc_pkg;
    // Frame layout
    localparam int ADDR_BITS = 3;
    localparam int DATA_BITS = 8;
    localparam int SHIFT_BITS = ADDR_BITS + DATA_BITS;
    localparam int SEL_LINES = 8;
    localparam logic [3:0] BIT_COUNT_W = 4'hb;
    // Register addresses
    localparam logic [2:0] BANDWIDTH_SELECT_ADDR = 3'h4;
    localparam logic [2:0] AMPLITUDE_THRESHOLD_ADDR = 3'h5;
    // Field positions
    localparam int BW_MSB = 7;
    localparam int BW_LSB = 4;
    localparam int AMP_MSB = 7;
    localparam int AMP_LSB = 6;
    localparam int THR_MSB = 5;
    localparam int THR_LSB = 0;
    // Reset values, no documented value
    localparam logic [7:0] BANDWIDTH_SELECT_RST = 8'h00;
    localparam logic [7:0] AMPLITUDE_THRESHOLD_RST = 8'h00;
    // Decode of select lines
    localparam logic [7:0] SEL_ONE = 8'h01;
endpackage

// File: two_wire_control_write_port.sv
`timescale 1ns/1ps
module two_wire_control_write_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic amplitude_meets_threshold,
    output logic [3:0] bandwidth_code,
    output logic [1:0] amplitude_code,
    output logic [5:0] threshold_resistor_code,
    output logic signal_present_out,
    output logic signal_lost_out,
    output logic signal_lost_out_oe,
    output logic frame_active,
    output logic [7:0] register_select
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic amp_m_q, amp_s_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            amp_m_q <= 1'b0;
            amp_s_q <= 1'b0;
        end else begin
            scl_m_q <= serial_clock;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= serial_data;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            amp_m_q <= amplitude_meets_threshold;
            amp_s_q <= amp_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition detection

    wire scl_rise = scl_s_q && !scl_p_q;
    wire start_seen = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    // Clock rose low to high earlier in this high phase, then data rises
    wire stop_seen = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame state machine

    typedef enum logic [1:0] {
        IDLE = 2'b01,
        COLLECT = 2'b10
    } frame_state_e;

    frame_state_e state_q, state_d;
    logic [twc_pkg::SHIFT_BITS-1:0] shift_q, shift_d;
    logic [3:0] count_q, count_d;

    wire frame_full = (count_q == twc_pkg::BIT_COUNT_W);
    wire commit = (state_q == COLLECT) && stop_seen && frame_full;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        count_d = count_q;
        case (state_q)
            IDLE: begin
                if (start_seen) begin
                    state_d = COLLECT;
                    count_d = 4'h0;
                end
            end
            COLLECT: begin
                if (start_seen) begin
                    count_d = 4'h0;
                end else if (stop_seen) begin
                    state_d = IDLE;
                end else if (scl_rise && !frame_full) begin
                    // Msb first, bit taken while clock high
                    shift_d = {shift_q[twc_pkg::SHIFT_BITS-2:0], sda_s_q};
                    count_d = count_q + 4'h1;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IDLE;
            shift_q <= '0;
            count_q <= 4'h0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and register load

    wire [2:0] addr_field = shift_q[twc_pkg::SHIFT_BITS-1:twc_pkg::DATA_BITS];
    wire [7:0] data_field = shift_q[twc_pkg::DATA_BITS-1:0];
    wire [7:0] sel_lines = twc_pkg::SEL_ONE << addr_field;
    wire load_bw = commit && sel_lines[twc_pkg::BANDWIDTH_SELECT_ADDR];
    wire load_at = commit && sel_lines[twc_pkg::AMPLITUDE_THRESHOLD_ADDR];

    logic [7:0] bandwidth_select_q;
    logic [7:0] amplitude_and_threshold_select_q;
    logic [7:0] select_q;

    // Other select lines load nothing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bandwidth_select_q <= twc_pkg::BANDWIDTH_SELECT_RST;
            amplitude_and_threshold_select_q <= twc_pkg::AMPLITUDE_THRESHOLD_RST;
            select_q <= 8'h00;
        end else begin
            if (load_bw) begin
                bandwidth_select_q <= data_field;
            end
            if (load_at) begin
                amplitude_and_threshold_select_q <= data_field;
            end
            if (commit) begin
                select_q <= sel_lines;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs and signal detect

    logic present_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            present_q <= 1'b0;
        end else begin
            present_q <= amp_s_q;
        end
    end

    // Code 0 widest bandwidth, code 15 narrowest
    assign bandwidth_code = bandwidth_select_q[twc_pkg::BW_MSB:twc_pkg::BW_LSB];
    assign amplitude_code =
        amplitude_and_threshold_select_q[twc_pkg::AMP_MSB:twc_pkg::AMP_LSB];
    // Bit high closes its shunt, so larger code means lower resistance
    assign threshold_resistor_code =
        amplitude_and_threshold_select_q[twc_pkg::THR_MSB:twc_pkg::THR_LSB];
    assign signal_present_out = present_q;
    // Open-drain: drive low only while signal present, pullup gives high
    assign signal_lost_out = 1'b0;
    assign signal_lost_out_oe = present_q;
    assign frame_active = (state_q == COLLECT);
    assign register_select = select_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence stop_with_bw_s;
        (state_q == COLLECT) && stop_seen && frame_full
            && addr_field == twc_pkg::BANDWIDTH_SELECT_ADDR;
    endsequence

    sequence stop_with_at_s;
        (state_q == COLLECT) && stop_seen && frame_full
            && addr_field == twc_pkg::AMPLITUDE_THRESHOLD_ADDR;
    endsequence

    bw_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_with_bw_s |=> bandwidth_code == $past(data_field[twc_pkg::BW_MSB:twc_pkg::BW_LSB]))
        else $error("bandwidth register not loaded on stop");

    at_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        stop_with_at_s |=> {amplitude_code, threshold_resistor_code} == $past(data_field))
        else $error("amplitude threshold register not loaded on stop");

    unused_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        commit && addr_field != twc_pkg::BANDWIDTH_SELECT_ADDR
            && addr_field != twc_pkg::AMPLITUDE_THRESHOLD_ADDR
            |=> $stable(bandwidth_select_q) && $stable(amplitude_and_threshold_select_q))
        else $error("unused address changed a register");

    restart_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == COLLECT) && start_seen |=> count_q == 4'h0 ##1 !commit)
        else $error("restart did not clear bit collection");

    start_detect_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == IDLE) && start_seen |=> frame_active)
        else $error("start not recognised");

    stop_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == COLLECT) && stop_seen && !start_seen |=> !frame_active)
        else $error("stop did not end frame");

    shift_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == COLLECT) && scl_rise && !frame_full && !start_seen && !stop_seen
            |=> shift_q[0] == $past(sda_s_q) && count_q == $past(count_q) + 4'h1)
        else $error("bit not shifted on clock high");

    decode_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        commit |=> $onehot(register_select))
        else $error("select lines not one-hot");

    lost_present_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        amp_s_q |=> signal_present_out && signal_lost_out_oe && !signal_lost_out)
        else $error("signal present not shown");

    lost_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !amp_s_q |=> !signal_present_out && !signal_lost_out_oe && !signal_lost_out)
        else $error("signal lost not shown");

    sequence bit_edge_s;
        (state_q == COLLECT) && scl_rise && !frame_full;
    endsequence

    sequence full_frame_s;
        (state_q == COLLECT) && frame_full && !start_seen && !stop_seen;
    endsequence

    sequence short_stop_s;
        (state_q == COLLECT) && stop_seen && !frame_full;
    endsequence

    bit_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bit_edge_s |=> count_q <= twc_pkg::BIT_COUNT_W && $changed(count_q))
        else $error("bit edge not counted");

    count_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        count_q <= twc_pkg::BIT_COUNT_W)
        else $error("bit count beyond frame length");

    extra_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        full_frame_s |=> $stable(shift_q) && frame_full)
        else $error("bits beyond frame length were taken");

    short_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        short_stop_s |=> $stable(bandwidth_select_q)
            && $stable(amplitude_and_threshold_select_q) && !frame_active)
        else $error("short frame changed a register");

    load_only_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !commit |=> $stable(bandwidth_select_q)
            && $stable(amplitude_and_threshold_select_q))
        else $error("register changed without stop");

    restart_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == COLLECT) && start_seen |=> $stable(bandwidth_select_q)
            && $stable(amplitude_and_threshold_select_q))
        else $error("restart changed a register");

    commit_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        commit |=> !commit)
        else $error("one stop loaded twice");

    select_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        commit |=> register_select == (twc_pkg::SEL_ONE << $past(addr_field)))
        else $error("select line does not match address");

    select_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !commit |=> $stable(register_select))
        else $error("select lines changed without stop");

    frame_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == IDLE) && stop_seen |=> $stable(register_select) && !frame_active)
        else $error("stop outside a frame had an effect");

    start_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == IDLE) && start_seen |=> count_q == 4'h0)
        else $error("start did not clear bit count");

    idle_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == IDLE) && !start_seen |=> $stable(shift_q) && !frame_active)
        else $error("bits taken outside a frame");

endmodule // two_wire_control_write_port

// File: serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clock,
    output logic serial_data
);
    logic clk_low_q = 1'b0;
    logic dat_low_q = 1'b0;
    // Open-drain drivers, pull-up gives high when released
    assign serial_clock = clk_low_q ? 1'b0 : 1'b1;
    assign serial_data = dat_low_q ? 1'b0 : 1'b1;

    // Line edges sit 2.5 ns off every sampling edge; both lines go high before data falls
    task automatic start();
        #22.5 dat_low_q = 1'b0;
        #40 clk_low_q = 1'b0;
        #65 dat_low_q = 1'b1;
        #60 clk_low_q = 1'b1;
        #2.5;
    endtask

    task automatic send_bit(input logic b);
        #22.5 dat_low_q = !b;
        #45 clk_low_q = 1'b0;
        #55 clk_low_q = 1'b1;
        #2.5;
    endtask

    task automatic stop();
        #22.5 dat_low_q = 1'b1;
        #45 clk_low_q = 1'b0;
        #60 dat_low_q = 1'b0;
        #62.5;
    endtask

    task automatic send_bits(input logic [10:0] f, input int n);
        for (int i = 10; i > 10 - n; i--) begin
            send_bit(f[i]);
        end
    endtask

    task automatic write(input logic [2:0] a, input logic [7:0] d);
        start();
        send_bits({a, d}, 11);
        stop();
    endtask
endmodule // serial_host_model

// File: two_wire_control_write_port_tb.sv
`timescale 1ns/1ps
module two_wire_control_write_port_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic amp_ok = 1'b0;
    wire serial_clock;
    wire serial_data;
    logic [3:0] bandwidth_code;
    logic [1:0] amplitude_code;
    logic [5:0] threshold_resistor_code;
    logic signal_present_out;
    logic signal_lost_out;
    logic signal_lost_out_oe;
    logic frame_active;
    logic [7:0] register_select;
    // Pull-up on the open-drain lost pin
    wire lost_pin = signal_lost_out_oe ? signal_lost_out : 1'b1;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    serial_host_model host (.serial_clock(serial_clock), .serial_data(serial_data));
    two_wire_control_write_port dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .serial_clock(serial_clock),
        .serial_data(serial_data), .amplitude_meets_threshold(amp_ok),
        .bandwidth_code(bandwidth_code), .amplitude_code(amplitude_code),
        .threshold_resistor_code(threshold_resistor_code),
        .signal_present_out(signal_present_out), .signal_lost_out(signal_lost_out),
        .signal_lost_out_oe(signal_lost_out_oe), .frame_active(frame_active),
        .register_select(register_select)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic regs(input logic [3:0] bw, input logic [7:0] r5, input logic [7:0] sel);
        repeat (8) @(negedge ref_clk);
        chk({bandwidth_code, 4'h0}, {bw, 4'h0});
        chk({amplitude_code, threshold_resistor_code}, r5);
        chk(register_select, sel);
        chk({7'h00, frame_active}, 8'h00);
    endtask

    initial begin
        repeat (8) @(negedge ref_clk);
        regs(4'h0, 8'h00, 8'h00);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            host.write(3'h4, {i[3:0], 4'h5});
            regs(i[3:0], 8'h00, 8'h10);
        end
        host.write(3'h5, 8'h9c);
        regs(4'hf, 8'h9c, 8'h20);
        host.write(3'h5, 8'h63);
        regs(4'hf, 8'h63, 8'h20);
        host.write(3'h3, 8'h00);
        regs(4'hf, 8'h63, 8'h08);
        host.write(3'h6, 8'h00);
        regs(4'hf, 8'h63, 8'h40);
        host.start();
        repeat (6) @(negedge ref_clk);
        chk({7'h00, frame_active}, 8'h01);
        host.send_bits(11'h400, 6);
        host.stop();
        regs(4'hf, 8'h63, 8'h40);
        host.start();
        host.send_bits(11'h500, 5);
        #60 host.start();
        host.send_bits({3'h4, 8'h30}, 11);
        host.stop();
        regs(4'h3, 8'h63, 8'h10);
        amp_ok = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk({6'h00, signal_present_out, signal_lost_out_oe}, 8'h03);
        chk({7'h00, signal_lost_out}, 8'h00);
        chk({7'h00, lost_pin}, 8'h00);
        amp_ok = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({6'h00, signal_present_out, signal_lost_out_oe}, 8'h00);
        chk({7'h00, lost_pin}, 8'h01);
        give_verdict();
    end
endmodule // two_wire_control_write_port_tb
